// ===== rtl/radio_irq_source_mux.sv
// Interrupt flag latching, source muxes and pin routing of the radio
`timescale 1ns/1ns
`include "radio_irq_map.svh"
// Notes on behaviour
// - Packet-received code shows a latched flag set on a complete packet.
// - Sleep-timer code shows a latched flag set on sleep counter timeout.
// - Receive-timeout code shows a latched flag set on receive counter expiry.
// - Transmit-done code shows a latched flag set when transmission ends.
// - Receive queue non-empty code follows the queue level directly.
// - Receive queue level code follows the over-threshold level.
// - Receive queue full code follows the full level.
// - Byte-written code gives one pulse per byte written to receive queue.
// - Receive overflow code follows the overflow level.
// - Transmit queue non-empty code follows the queue level.
// - Transmit queue level code follows the over-threshold level.
// - Transmit queue full code follows the full level.
// - Four codes mirror standby, synthesiser, receive and transmit states.
// - Low battery code follows the detector level.
// - Busy code is high in calibration, receive and transmit, else low.
// - Packet-finished flag latches on packet, decode, node or conflict.
// - Decode or node errors restart decoder; conflict halts it until resumed.
// - Outputs active high; polarity bit set makes all active low.
// - Both outputs share codes and behaviour, each with its own select.
// - Codes 0 and 1 show receive and transmit activity; 2 signal validity.
// - Codes 3 to 6 show latched preamble, sync, node, CRC flags.
// - Each pin may carry either interrupt output as configured.
module radio_irq_source_mux
  import radio_irq_pkg::*;
#(
  parameter int SEL_W = 5,
  parameter int GPIO_COUNT = 3
)
(
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_N,
  // Radio core events, levels and state
  input wire radio_event_t EVENTS,
  input wire radio_level_t LEVELS,
  input wire radio_state_t RADIO_STATE,
  // Source selection and polarity
  input wire logic [SEL_W-1:0] IRQ_OUT_A_SOURCE_SELECT,
  input wire logic [SEL_W-1:0] IRQ_OUT_B_SOURCE_SELECT,
  input wire logic IRQ_POLARITY_INVERT,
  // Software clear strobes
  input wire logic [`LF_COUNT-1:0] FLAG_CLEAR,
  input wire logic DECODER_RESUME,
  // Pin routing, two bits per pin
  input wire logic [2*GPIO_COUNT-1:0] GPIO_ROUTE,
  // Interrupt outputs
  output logic IRQ_OUT_A,
  output logic IRQ_OUT_B,
  output logic [`LF_COUNT-1:0] FLAG_STATUS,
  // Decoder control
  output logic DECODER_RESTART,
  output logic DECODER_HALTED,
  // Pin drive
  output logic [GPIO_COUNT-1:0] GPIO_IRQ_OUT,
  output logic [GPIO_COUNT-1:0] GPIO_IRQ_OE
);

  localparam int SRC_N = 1 << SEL_W;

  typedef struct packed {
    logic [1:0] irq;
    logic [`LF_COUNT-1:0] flags;
    logic halted;
    logic restart;
    logic [GPIO_COUNT-1:0] gpio;
    logic [GPIO_COUNT-1:0] gpio_oe;
  } state_t;

  state_t cur_q;
  state_t nxt_d;
  logic [SRC_N-1:0] src;
  logic [`LF_COUNT-1:0] flag_set;
  logic [1:0] mux_level;
  logic [SEL_W-1:0] sel [2];
  logic in_receive;
  logic in_transmit;
  logic [1:0] route;

  assign in_receive = (RADIO_STATE == receive_state);
  assign in_transmit = (RADIO_STATE == transmit_state);
  assign sel[0] = IRQ_OUT_A_SOURCE_SELECT;
  assign sel[1] = IRQ_OUT_B_SOURCE_SELECT;

  // Source vector indexed by selection code
  always_comb
  begin
    src = '0;
    src[`SEL_RX_ACTIVE] = LEVELS.cal_toward_rx | in_receive;
    src[`SEL_TX_ACTIVE] = LEVELS.cal_toward_tx | in_transmit;
    src[`SEL_SIGNAL_VALID] = LEVELS.signal_strength_valid;
    src[`SEL_PREAMBLE] = cur_q.flags[`LF_PREAMBLE];
    src[`SEL_SYNC] = cur_q.flags[`LF_SYNC];
    src[`SEL_NODE] = cur_q.flags[`LF_NODE];
    src[`SEL_CRC] = cur_q.flags[`LF_CRC];
    src[`SEL_PKT_RECEIVED] = cur_q.flags[`LF_PKT_RECEIVED];
    src[`SEL_SLEEP_TMO] = cur_q.flags[`LF_SLEEP_TMO];
    src[`SEL_RECEIVE_TIMEOUT_FLAG] = cur_q.flags[`LF_RECEIVE_TIMEOUT_FLAG];
    src[`SEL_TX_DONE] = cur_q.flags[`LF_TX_DONE];
    src[`SEL_RXQ_NONEMPTY] = LEVELS.rxq_nonempty;
    src[`SEL_RXQ_LEVEL] = LEVELS.rxq_over_level;
    src[`SEL_RXQ_FULL] = LEVELS.rxq_full;
    src[`SEL_RXQ_BYTE] = LEVELS.rxq_byte_written_pulse;
    src[`SEL_RXQ_OVERFLOW] = LEVELS.rxq_overflow_flag;
    src[`SEL_TXQ_NONEMPTY] = LEVELS.txq_nonempty;
    src[`SEL_TXQ_LEVEL] = LEVELS.txq_over_level;
    src[`SEL_TXQ_FULL] = LEVELS.txq_full;
    src[`SEL_STANDBY] = (RADIO_STATE == standby_state);
    src[`SEL_SYNTH] = (RADIO_STATE == receive_synth_state) |
                      (RADIO_STATE == transmit_synth_state);
    src[`SEL_RECEIVE] = in_receive;
    src[`SEL_TRANSMIT] = in_transmit;
    src[`SEL_LOW_BATTERY] = LEVELS.low_battery_flag;
    src[`SEL_BUSY] = LEVELS.cal_toward_rx | LEVELS.cal_toward_tx |
                     in_receive | in_transmit;
    src[`SEL_PKT_FINISHED] = cur_q.flags[`LF_PKT_FINISHED];
  end

  // Same mux for both outputs, separate selects
  for (genvar i = 0; i < 2; i++)
  begin : g_out
    irq_source_mux #(
      .SEL_W(SEL_W)
    ) u_mux (
      .sources(src),
      .select(sel[i]),
      .invert(IRQ_POLARITY_INVERT),
      .level(mux_level[i])
    );
  end

  // Flag set terms from events
  always_comb
  begin
    flag_set = '0;
    flag_set[`LF_PREAMBLE] = EVENTS.preamble_found;
    flag_set[`LF_SYNC] = EVENTS.sync_found;
    flag_set[`LF_NODE] = EVENTS.node_found;
    flag_set[`LF_CRC] = EVENTS.crc_passed;
    flag_set[`LF_PKT_RECEIVED] = EVENTS.packet_complete;
    flag_set[`LF_SLEEP_TMO] = EVENTS.sleep_timeout;
    flag_set[`LF_RECEIVE_TIMEOUT_FLAG] = EVENTS.receive_timeout;
    flag_set[`LF_TX_DONE] = EVENTS.transmit_done;
    flag_set[`LF_PKT_FINISHED] = EVENTS.packet_complete |
                                 EVENTS.manchester_error |
                                 EVENTS.node_mismatch |
                                 EVENTS.signal_conflict;
  end

  always_comb
  begin
    route = `ROUTE_NONE;
    nxt_d = cur_q;
    // Set beats clear in the same cycle
    nxt_d.flags = flag_set | (cur_q.flags & ~FLAG_CLEAR);
    nxt_d.restart = EVENTS.manchester_error | EVENTS.node_mismatch;
    nxt_d.halted = EVENTS.signal_conflict |
                   (cur_q.halted & ~DECODER_RESUME);
    nxt_d.irq = mux_level;
    for (int p = 0; p < GPIO_COUNT; p++)
    begin
      route = GPIO_ROUTE[2*p +: 2];
      nxt_d.gpio[p] = (route == `ROUTE_A) ? mux_level[0] :
                      (route == `ROUTE_B) ? mux_level[1] :
                      1'b0;
      nxt_d.gpio_oe[p] = (route == `ROUTE_A) |
                         (route == `ROUTE_B);
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      cur_q <= '0;
    end
    else
    begin
      cur_q <= nxt_d;
    end
  end

  assign IRQ_OUT_A = cur_q.irq[0];
  assign IRQ_OUT_B = cur_q.irq[1];
  assign FLAG_STATUS = cur_q.flags;
  assign DECODER_RESTART = cur_q.restart;
  assign DECODER_HALTED = cur_q.halted;
  assign GPIO_IRQ_OUT = cur_q.gpio;
  assign GPIO_IRQ_OE = cur_q.gpio_oe;

  // Checks

  property p_pkt_received_irq;
    @(posedge CORE_CLK) disable iff (!RST_N)
    (EVENTS.packet_complete &&
     IRQ_OUT_A_SOURCE_SELECT == `SEL_PKT_RECEIVED &&
     !IRQ_POLARITY_INVERT) ##1
    ($stable(IRQ_OUT_A_SOURCE_SELECT) && !IRQ_POLARITY_INVERT)
    |=> IRQ_OUT_A;
  endproperty
  a_pkt_received_irq: assert property (p_pkt_received_irq)
    else $error("packet received event did not reach output a");

  property p_sleep_flag_holds;
    @(posedge CORE_CLK) disable iff (!RST_N)
    (FLAG_STATUS[`LF_SLEEP_TMO] && !FLAG_CLEAR[`LF_SLEEP_TMO])
    |=> FLAG_STATUS[`LF_SLEEP_TMO];
  endproperty
  a_sleep_flag_holds: assert property (p_sleep_flag_holds)
    else $error("sleep timeout flag dropped without clear");

  property p_receive_timeout_flag_set_wins;
    @(posedge CORE_CLK) disable iff (!RST_N)
    (EVENTS.receive_timeout && FLAG_CLEAR[`LF_RECEIVE_TIMEOUT_FLAG])
    |=> FLAG_STATUS[`LF_RECEIVE_TIMEOUT_FLAG];
  endproperty
  a_receive_timeout_flag_set_wins: assert property (p_receive_timeout_flag_set_wins)
    else $error("receive timeout lost against clear");

  property p_tx_done_clears;
    @(posedge CORE_CLK) disable iff (!RST_N)
    (FLAG_CLEAR[`LF_TX_DONE] && !EVENTS.transmit_done)
    |=> !FLAG_STATUS[`LF_TX_DONE];
  endproperty
  a_tx_done_clears: assert property (p_tx_done_clears)
    else $error("transmit done flag not cleared");

  property p_rxq_nonempty_follows;
    @(posedge CORE_CLK) disable iff (!RST_N)
    (IRQ_OUT_A_SOURCE_SELECT == `SEL_RXQ_NONEMPTY)
    |=> IRQ_OUT_A == ($past(LEVELS.rxq_nonempty) ^
                      $past(IRQ_POLARITY_INVERT));
  endproperty
  a_rxq_nonempty_follows: assert property (p_rxq_nonempty_follows)
    else $error("output a does not follow receive queue level");

  property p_byte_pulse;
    @(posedge CORE_CLK) disable iff (!RST_N)
    (IRQ_OUT_B_SOURCE_SELECT == `SEL_RXQ_BYTE && !IRQ_POLARITY_INVERT &&
     LEVELS.rxq_byte_written_pulse) ##1
    ($stable(IRQ_OUT_B_SOURCE_SELECT) && !IRQ_POLARITY_INVERT &&
     !LEVELS.rxq_byte_written_pulse)
    |-> IRQ_OUT_B ##1 !IRQ_OUT_B;
  endproperty
  a_byte_pulse: assert property (p_byte_pulse)
    else $error("byte written pulse not one cycle on output b");

  property p_standby_level;
    @(posedge CORE_CLK) disable iff (!RST_N)
    (IRQ_OUT_B_SOURCE_SELECT == `SEL_STANDBY && !IRQ_POLARITY_INVERT &&
     RADIO_STATE == standby_state) |=> IRQ_OUT_B;
  endproperty
  a_standby_level: assert property (p_standby_level)
    else $error("standby state not shown on output b");

  property p_busy_inverted;
    @(posedge CORE_CLK) disable iff (!RST_N)
    (IRQ_OUT_A_SOURCE_SELECT == `SEL_BUSY && IRQ_POLARITY_INVERT &&
     RADIO_STATE == transmit_state) |=> !IRQ_OUT_A;
  endproperty
  a_busy_inverted: assert property (p_busy_inverted)
    else $error("busy level wrong under inverted polarity");

  property p_conflict_halts;
    @(posedge CORE_CLK) disable iff (!RST_N)
    EVENTS.signal_conflict
    |=> (DECODER_HALTED && FLAG_STATUS[`LF_PKT_FINISHED] &&
         !DECODER_RESTART);
  endproperty
  a_conflict_halts: assert property (p_conflict_halts)
    else $error("conflict did not halt decoder and flag packet");

  property p_error_restarts;
    @(posedge CORE_CLK) disable iff (!RST_N)
    (EVENTS.manchester_error || EVENTS.node_mismatch)
    |=> (DECODER_RESTART && FLAG_STATUS[`LF_PKT_FINISHED]);
  endproperty
  a_error_restarts: assert property (p_error_restarts)
    else $error("decode error did not restart decoder");

  property p_undefined_inactive;
    @(posedge CORE_CLK) disable iff (!RST_N)
    (IRQ_OUT_A_SOURCE_SELECT > SEL_W'(`SEL_LAST))
    |=> IRQ_OUT_A == $past(IRQ_POLARITY_INVERT);
  endproperty
  a_undefined_inactive: assert property (p_undefined_inactive)
    else $error("undefined code drove output a active");

  property p_pin_route_b;
    @(posedge CORE_CLK) disable iff (!RST_N)
    (GPIO_ROUTE[1:0] == `ROUTE_B)
    |=> (GPIO_IRQ_OE[0] && GPIO_IRQ_OUT[0] == IRQ_OUT_B);
  endproperty
  a_pin_route_b: assert property (p_pin_route_b)
    else $error("pin 0 does not carry output b");

  c_pkt_finished: cover property (@(posedge CORE_CLK) disable iff (!RST_N)
    IRQ_OUT_A_SOURCE_SELECT == `SEL_PKT_FINISHED ##1 IRQ_OUT_A);
  c_clear_after_set: cover property (@(posedge CORE_CLK)
    disable iff (!RST_N)
    FLAG_STATUS[`LF_PKT_RECEIVED] ##1 !FLAG_STATUS[`LF_PKT_RECEIVED]);
  c_resume: cover property (@(posedge CORE_CLK) disable iff (!RST_N)
    DECODER_HALTED ##1 !DECODER_HALTED);
  c_inverted_b: cover property (@(posedge CORE_CLK) disable iff (!RST_N)
    IRQ_POLARITY_INVERT && !IRQ_OUT_B);

endmodule

// ===== rtl/radio_irq_map.svh
// Selection codes, flag positions and routing codes of the interrupt mux
`ifndef RADIO_IRQ_MAP_SVH
`define RADIO_IRQ_MAP_SVH

`define SEL_RX_ACTIVE     5'h00
`define SEL_TX_ACTIVE     5'h01
`define SEL_SIGNAL_VALID  5'h02
`define SEL_PREAMBLE      5'h03
`define SEL_SYNC          5'h04
`define SEL_NODE          5'h05
`define SEL_CRC           5'h06
`define SEL_PKT_RECEIVED  5'h07
`define SEL_SLEEP_TMO     5'h08
`define SEL_RECEIVE_TIMEOUT_FLAG        5'h09
`define SEL_TX_DONE       5'h0a
`define SEL_RXQ_NONEMPTY  5'h0b
`define SEL_RXQ_LEVEL     5'h0c
`define SEL_RXQ_FULL      5'h0d
`define SEL_RXQ_BYTE      5'h0e
`define SEL_RXQ_OVERFLOW  5'h0f
`define SEL_TXQ_NONEMPTY  5'h10
`define SEL_TXQ_LEVEL     5'h11
`define SEL_TXQ_FULL      5'h12
`define SEL_STANDBY       5'h13
`define SEL_SYNTH         5'h14
`define SEL_RECEIVE       5'h15
`define SEL_TRANSMIT      5'h16
`define SEL_LOW_BATTERY   5'h17
`define SEL_BUSY          5'h18
`define SEL_PKT_FINISHED  5'h19
`define SEL_LAST          5'h19

// Latched flag positions
`define LF_PREAMBLE      0
`define LF_SYNC          1
`define LF_NODE          2
`define LF_CRC           3
`define LF_PKT_RECEIVED  4
`define LF_SLEEP_TMO     5
`define LF_RECEIVE_TIMEOUT_FLAG        6
`define LF_TX_DONE       7
`define LF_PKT_FINISHED  8
`define LF_COUNT         9

// Pin routing codes
`define ROUTE_NONE  2'h0
`define ROUTE_A     2'h1
`define ROUTE_B     2'h2

`endif

// ===== rtl/radio_irq_pkg.sv
// Types shared by the radio interrupt source mux
package radio_irq_pkg;

  typedef enum logic [2:0]
  {
    sleep_state,
    standby_state,
    receive_synth_state,
    transmit_synth_state,
    receive_state,
    transmit_state
  } radio_state_t;

  // One-cycle event pulses from the radio core
  typedef struct packed {
    logic preamble_found;
    logic sync_found;
    logic node_found;
    logic crc_passed;
    logic packet_complete;
    logic sleep_timeout;
    logic receive_timeout;
    logic transmit_done;
    logic manchester_error;
    logic node_mismatch;
    logic signal_conflict;
  } radio_event_t;

  // Levels from FIFOs, detectors and synthesiser
  typedef struct packed {
    logic rxq_nonempty;
    logic rxq_over_level;
    logic rxq_full;
    logic rxq_byte_written_pulse;
    logic rxq_overflow_flag;
    logic txq_nonempty;
    logic txq_over_level;
    logic txq_full;
    logic low_battery_flag;
    logic signal_strength_valid;
    logic cal_toward_rx;
    logic cal_toward_tx;
  } radio_level_t;

endpackage

// ===== rtl/irq_source_mux.sv
// One interrupt output: source selection with polarity
`timescale 1ns/1ns
`include "radio_irq_map.svh"
module irq_source_mux
  import radio_irq_pkg::*;
#(
  parameter int SEL_W = 5
)
(
  // Candidate sources, indexed by selection code
  input wire logic [(1<<SEL_W)-1:0] sources,
  // Selection and polarity
  input wire logic [SEL_W-1:0] select,
  input wire logic invert,
  // Selected level after polarity
  output logic level
);

  logic defined;

  assign defined = (select <= SEL_W'(`SEL_LAST));
  // Codes beyond the table read inactive
  assign level = (defined & sources[select]) ^ invert;

endmodule

// ===== tb/mcu_irq_model.sv
// Behavioural model of the MCU side that services latched flags
`timescale 1ns/1ns
`include "radio_irq_map.svh"
module mcu_irq_model
(
  // Clock
  input wire logic clk,
  // Service request from the bench
  input wire logic service_req,
  input wire logic [`LF_COUNT-1:0] service_mask,
  // Clear strobes toward the flags
  output logic [`LF_COUNT-1:0] flag_clear
);
  initial flag_clear = '0;

  // One-cycle clear strobe per service request
  always @(posedge clk)
  begin
    flag_clear <= #1 service_req ? service_mask : '0;
  end
endmodule

// ===== tb/test_radio_irq_source_mux.sv
// Self-checking bench for the radio interrupt source mux
`timescale 1ns/1ns
`include "radio_irq_map.svh"
module test_radio_irq_source_mux import radio_irq_pkg::*;;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  radio_event_t events = '0;
  radio_level_t levels = '0;
  radio_state_t state = sleep_state;
  logic [4:0] sel_a = 5'h00;
  logic [4:0] sel_b = 5'h00;
  logic invert = 1'b0;
  logic resume = 1'b0;
  logic svc_req = 1'b0;
  logic [`LF_COUNT-1:0] svc_mask = '0;
  logic [`LF_COUNT-1:0] flag_clear;
  logic [`LF_COUNT-1:0] flags;
  logic irq_a, irq_b, restart, halted;
  logic [2:0] pin_out, pin_oe;
  logic [5:0] gpio_route = 6'h39;
  int err_total = 0;
  int comparisons = 0;
  int cycles = 0;

  always #4 core_clk = ~core_clk;

  radio_irq_source_mux radio_irq_source_mux_inst
  (
    .CORE_CLK(core_clk),
    .RST_N(rst_n),
    .EVENTS(events),
    .LEVELS(levels),
    .RADIO_STATE(state),
    .IRQ_OUT_A_SOURCE_SELECT(sel_a),
    .IRQ_OUT_B_SOURCE_SELECT(sel_b),
    .IRQ_POLARITY_INVERT(invert),
    .FLAG_CLEAR(flag_clear),
    .DECODER_RESUME(resume),
    .GPIO_ROUTE(gpio_route),
    .IRQ_OUT_A(irq_a),
    .IRQ_OUT_B(irq_b),
    .FLAG_STATUS(flags),
    .DECODER_RESTART(restart),
    .DECODER_HALTED(halted),
    .GPIO_IRQ_OUT(pin_out),
    .GPIO_IRQ_OE(pin_oe)
  );

  mcu_irq_model mcu_irq_model_inst
  (
    .clk(core_clk),
    .service_req(svc_req),
    .service_mask(svc_mask),
    .flag_clear(flag_clear)
  );

  task automatic end_sim();
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Hang guard, well above the expected run length
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      err_total = err_total + 1;
      end_sim();
    end
  end

  task automatic chk_bit(input string what, input logic exp, input logic got);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic chk_vec(input string what, input logic [8:0] exp,
                         input logic [8:0] got);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic service(input logic [8:0] mask);
    svc_req = 1'b1;
    svc_mask = mask;
    step(1);
    svc_req = 1'b0;
    step(2);
  endtask

  task automatic t_levels();
    logic [4:0] codes [10] = '{5'h02, 5'h0b, 5'h0c, 5'h0d, 5'h0e,
                               5'h0f, 5'h10, 5'h11, 5'h12, 5'h17};
    int bits [10] = '{2, 11, 10, 9, 8, 7, 6, 5, 4, 3};
    for (int i = 0; i < 10; i++)
    begin
      sel_a = codes[i];
      sel_b = codes[i];
      step(1);
      levels[bits[i]] = 1'b1;
      step(1);
      chk_bit("irq_a level", 1'b1, irq_a);
      chk_bit("irq_b level", 1'b1, irq_b);
      chk_vec("pin out", 9'h003, {7'h00, pin_out[1:0]});
      chk_vec("pin oe", 9'h003, {6'h00, pin_oe});
      levels[bits[i]] = 1'b0;
      step(1);
      chk_bit("irq_a self clear", 1'b0, irq_a);
    end
  endtask

  task automatic t_states();
    logic [4:0] codes [7] = '{5'h13, 5'h14, 5'h15, 5'h16, 5'h18, 5'h00, 5'h01};
    logic [6:0] exp;
    sel_b = 5'h13;
    for (int s = 0; s < 6; s++)
    begin
      exp = {s == 1, s == 2 || s == 3, s == 4, s == 5, s >= 4, s == 4, s == 5};
      state = radio_state_t'(s);
      for (int c = 0; c < 7; c++)
      begin
        sel_a = codes[c];
        step(1);
        chk_bit("irq_a state", exp[6-c], irq_a);
        chk_bit("irq_b standby", s == 1, irq_b);
      end
    end
    state = sleep_state;
    levels.cal_toward_rx = 1'b1;
    sel_a = 5'h18;
    step(1);
    chk_bit("irq_a busy cal", 1'b1, irq_a);
    sel_a = 5'h00;
    step(1);
    chk_bit("irq_a rx cal", 1'b1, irq_a);
    sel_a = 5'h01;
    step(1);
    chk_bit("irq_a tx cal", 1'b0, irq_a);
    levels.cal_toward_rx = 1'b0;
  endtask

  task automatic t_undefined();
    levels = '1;
    state = receive_state;
    for (int c = 26; c < 32; c++)
    begin
      sel_a = 5'(c);
      invert = 1'b0;
      step(1);
      chk_bit("irq_a undefined", 1'b0, irq_a);
      invert = 1'b1;
      step(1);
      chk_bit("irq_a undefined inv", 1'b1, irq_a);
    end
    sel_a = 5'h0b;
    step(1);
    chk_bit("irq_a active low", 1'b0, irq_a);
    state = transmit_state;
    sel_a = 5'h18;
    step(1);
    chk_bit("irq_a busy inverted", 1'b0, irq_a);
    levels = '0;
    state = sleep_state;
    invert = 1'b0;
    step(1);
  endtask

  task automatic t_latched();
    logic [8:0] exp;
    for (int i = 0; i < 8; i++)
    begin
      sel_a = 5'(3 + i);
      exp = 9'(1 << i) | (i == 4 ? 9'h100 : 9'h000);
      events[10-i] = 1'b1;
      step(1);
      events[10-i] = 1'b0;
      chk_vec("flags set", exp, flags);
      step(4);
      chk_bit("irq_a held", 1'b1, irq_a);
      service(exp);
      chk_vec("flags cleared", 9'h000, flags);
      chk_bit("irq_a cleared", 1'b0, irq_a);
    end
  endtask

  task automatic t_finished();
    for (int j = 0; j < 3; j++)
    begin
      sel_a = 5'h19;
      events[j] = 1'b1;
      step(1);
      events[j] = 1'b0;
      chk_vec("finished flag", 9'h100, flags);
      chk_bit("restart", j != 0, restart);
      chk_bit("halted", j == 0, halted);
      step(3);
      chk_bit("irq_a finished", 1'b1, irq_a);
      chk_bit("restart end", 1'b0, restart);
      chk_bit("halted held", j == 0, halted);
      service(9'h100);
      chk_bit("irq_a finished clr", 1'b0, irq_a);
      if (j == 0)
      begin
        resume = 1'b1;
        step(1);
        resume = 1'b0;
        chk_bit("halted resumed", 1'b0, halted);
      end
    end
  endtask

  task automatic t_route_and_races();
    sel_a = 5'h0b;
    sel_b = 5'h10;
    levels = '0;
    levels.rxq_nonempty = 1'b1;
    gpio_route = 6'h06;
    step(1);
    chk_vec("pin out swapped", 9'h002, {6'h00, pin_out});
    chk_vec("pin oe swapped", 9'h003, {6'h00, pin_oe});
    levels.rxq_nonempty = 1'b0;
    levels.txq_nonempty = 1'b1;
    step(1);
    chk_vec("pin out b", 9'h001, {6'h00, pin_out});
    chk_bit("irq_a independent", 1'b0, irq_a);
    levels = '0;
    gpio_route = 6'h39;
    sel_a = 5'h09;
    svc_mask = 9'h040;
    svc_req = 1'b1;
    step(1);
    svc_req = 1'b0;
    events.receive_timeout = 1'b1;
    step(1);
    events.receive_timeout = 1'b0;
    chk_vec("set beats clear", 9'h040, flags);
    service(9'h040);
    chk_vec("receive_timeout_flag cleared", 9'h000, flags);
    events.signal_conflict = 1'b1;
    resume = 1'b1;
    step(1);
    events.signal_conflict = 1'b0;
    chk_bit("conflict beats resume", 1'b1, halted);
    step(1);
    resume = 1'b0;
    chk_bit("halted released", 1'b0, halted);
    service(9'h100);
  endtask

  task automatic t_reset_midrun();
    invert = 1'b1;
    events.sync_found = 1'b1;
    step(1);
    events.sync_found = 1'b0;
    chk_vec("flags before reset", 9'h002, flags);
    rst_n = 1'b0;
    #1;
    chk_vec("flags in reset", 9'h000, flags);
    chk_bit("irq_a in reset", 1'b0, irq_a);
    step(2);
    rst_n = 1'b1;
    step(1);
    chk_bit("irq_a after reset", 1'b1, irq_a);
    chk_vec("flags after reset", 9'h000, flags);
    invert = 1'b0;
    step(1);
  endtask

  initial
  begin
    step(10);
    rst_n = 1'b1;
    step(1);
    chk_bit("irq_a idle", 1'b0, irq_a);
    t_levels();
    t_states();
    t_undefined();
    t_latched();
    t_finished();
    t_route_and_races();
    t_reset_midrun();
    end_sim();
  end
endmodule
